// File: verif/asmt_ctrl_sva.sv
`timescale 1ns/1ps

module asmt_ctrl_sva (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Handshakes
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_ack,
    input wire logic acc_ack,
    input wire logic acc_err,
    // Memory pins
    input wire asmt_pkg::asmt_pins_s pins
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_cs_fall;
        $fell(pins.cs_n[0]);
    endsequence

    sequence s_cs_rise;
        $rose(pins.cs_n[0]);
    endsequence

    sequence s_wb_take;
        $rose(wb_cyc && wb_stb);
    endsequence

    chk_oe_in_cs: assert property (!pins.oe_n |-> pins.cs_n != 4'hF)
        else $error("output enable outside chip select");
    chk_we_in_cs: assert property (!pins.we_n |-> pins.cs_n != 4'hF)
        else $error("write strobe outside chip select");
    chk_strobe_excl: assert property (!(!pins.oe_n && !pins.we_n))
        else $error("read and write strobes both active");
    chk_addr_setup: assert property (s_cs_fall |=> $stable(pins.addr))
        else $error("address moved in first selected cycle");
    chk_cs_gap: assert property (s_cs_rise |=> pins.cs_n[0])
        else $error("chip select reasserted without a gap");
    chk_done_after_cs: assert property (acc_ack && !acc_err |-> $past(pins.cs_n) != 4'hF)
        else $error("access finished without a memory cycle");
    chk_err_no_cs: assert property (acc_ack && acc_err |-> pins.cs_n == 4'hF)
        else $error("disabled region saw a chip select");
    chk_ack_pulse: assert property (acc_ack |=> !acc_ack)
        else $error("access acknowledge longer than one cycle");
    chk_wb_answer: assert property (s_wb_take |-> !wb_ack ##2 wb_ack)
        else $error("register acknowledge not two cycles after take");
    chk_wb_drop: assert property (wb_ack |=> !wb_ack)
        else $error("register acknowledge held");
    chk_one_cs: assert property ($onehot0(~pins.cs_n))
        else $error("more than one region selected");
endmodule : asmt_ctrl_sva

// File: verif/asmt_sram_model.sv
`timescale 1ns/1ps

module asmt_sram_model (
    // Clock
    input wire logic clock,
    // Controller pins
    input wire asmt_pkg::asmt_pins_s pins,
    input wire logic [3:0] stall,
    output logic wait_n,
    output logic [15:0] ext_data_in
);
    logic [15:0] mem [0:255];
    logic [15:0] last_r = 16'h0000;
    logic [3:0] wcnt_r = 4'h0;
    logic sel_r = 1'b0;
    logic sel;

    assign sel = (pins.cs_n != 4'hF);

    // Wait is held for a set number of strobe cycles from each select
    always @(posedge clock) begin
        sel_r <= sel;
        if (sel && !sel_r) wcnt_r <= stall;
        else if (wcnt_r != 4'h0 && !(pins.oe_n && pins.we_n)) wcnt_r <= wcnt_r - 4'h1;
        if (sel && !pins.we_n) mem[pins.addr[7:0]] <= pins.dout;
        if (sel && !pins.oe_n) last_r <= mem[pins.addr[7:0]];
    end

    // Released bus shows the inverse of the last word, so stale data cannot pass
    assign ext_data_in = (sel && !pins.oe_n) ? mem[pins.addr[7:0]] : ~last_r;
    assign wait_n = (wcnt_r == 4'h0);
endmodule : asmt_sram_model

// File: verif/testbench.sv
`timescale 1ns/1ps

module testbench;
    typedef struct packed {
        logic [15:0] ctl;
        logic [31:0] rt;
        logic [31:0] wt;
        logic w;
        logic [1:0] sz;
        logic [3:0] st;
        logic [7:0] lat;
    } asmt_row_s;

    logic clock, rst, wb_cyc, wb_stb, wb_we, wb_ack, acc_valid, acc_ack, acc_err, wait_n;
    logic [6:0] wb_adr;
    logic [3:0] wb_sel, stall;
    logic [31:0] wb_wdat, wb_rdat, acc_rdata, q;
    logic [15:0] ext_data_in;
    logic [1:0] bl_seen;
    asmt_pkg::asmt_req_s acc_req;
    asmt_pkg::asmt_pins_s pins;
    int err_count = 0;
    int check_count = 0;
    int n, hi_n, gap;

    asmt_row_s rows [12] = '{
        '{16'h0011, 32'h00000101, 32'h0, 1'b0, 2'h1, 4'h0, 8'h09},
        '{16'h0011, 32'h00000101, 32'h0, 1'b1, 2'h1, 4'h0, 8'h07},
        '{16'h0011, 32'h00000101, 32'h00000502, 1'b1, 2'h1, 4'h0, 8'h07},
        '{16'h4011, 32'h00000101, 32'h00000502, 1'b1, 2'h1, 4'h0, 8'h0C},
        '{16'h4011, 32'h00000101, 32'h00000502, 1'b0, 2'h1, 4'h0, 8'h09},
        '{16'h4011, 32'h30000121, 32'h30000121, 1'b0, 2'h1, 4'h0, 8'h0B},
        '{16'h0011, 32'h00000101, 32'h0, 1'b0, 2'h2, 4'h0, 8'h0E},
        '{16'h4059, 32'h10000101, 32'h10000101, 1'b0, 2'h1, 4'h0, 8'h09},
        '{16'h4059, 32'h20000101, 32'h20000101, 1'b0, 2'h1, 4'h0, 8'h09},
        '{16'h005B, 32'h00000111, 32'h0, 1'b0, 2'h1, 4'h0, 8'h0A},
        '{16'h8011, 32'h00000101, 32'h0, 1'b0, 2'h1, 4'h3, 8'h0C},
        '{16'h0211, 32'h00000101, 32'h0, 1'b0, 2'h1, 4'h3, 8'h09}
    };

    asmt_ctrl dut_u (.clock(clock), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdat(wb_wdat),
        .wb_rdat(wb_rdat), .wb_ack(wb_ack), .acc_valid(acc_valid), .acc_req(acc_req),
        .acc_ack(acc_ack), .acc_err(acc_err), .acc_rdata(acc_rdata), .pins(pins),
        .wait_n(wait_n), .ext_data_in(ext_data_in));

    asmt_sram_model mem_u (.clock(clock), .pins(pins), .stall(stall), .wait_n(wait_n),
        .ext_data_in(ext_data_in));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Length of the chip select high gap before each selection
    always @(posedge clock) begin
        if (pins.we_n === 1'b0) bl_seen = pins.bl_n;
        if (pins.cs_n[0] === 1'b1) hi_n++;
        else begin
            if (hi_n != 0) gap = hi_n;
            hi_n = 0;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        if (err_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic wb_xfer(input logic w, input logic [6:0] a, input logic [31:0] d);
        @(posedge clock);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        do @(posedge clock); while (wb_ack !== 1'b1);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb_xfer

    task automatic cfg(input logic [15:0] c, input logic [31:0] r, input logic [31:0] w);
        wb_xfer(1'b1, 7'h00, {16'h0000, c});
        wb_xfer(1'b1, 7'h04, r);
        wb_xfer(1'b1, 7'h08, w);
    endtask : cfg

    task automatic acc(input logic [27:0] a, input logic [1:0] sz, input logic w,
        input logic [31:0] d);
        @(posedge clock);
        acc_valid <= 1'b1;
        acc_req <= '{addr: a, size: sz, we: w, wdata: d};
        n = -1;
        do begin
            @(posedge clock);
            n++;
        end while (acc_ack !== 1'b1 && n < 200);
        acc_valid <= 1'b0;
    endtask : acc

    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        conclude();
    end

    initial begin
        rst = 1'b1;
        {wb_cyc, wb_stb, wb_we, acc_valid} = 4'h0;
        wb_adr = 7'h00;
        wb_sel = 4'hF;
        wb_wdat = 32'h0;
        acc_req = '0;
        stall = 4'h0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check(32'(pins.cs_n), 32'h0000000F);
        wb_xfer(1'b0, 7'h00, 32'h0);
        check(q, 32'h000030DA);
        wb_xfer(1'b0, 7'h10, 32'h0);
        check(q, 32'h000030D2);
        wb_xfer(1'b0, 7'h04, 32'h0);
        check(q, 32'h0FFFFFFF);
        wb_xfer(1'b0, 7'h0C, 32'h0);
        check(q, 32'h00000000);
        wb_xfer(1'b1, 7'h44, 32'hFFFFFFFF);
        wb_xfer(1'b0, 7'h44, 32'h0);
        check(q, 32'h00000000);
        foreach (rows[i]) begin
            cfg(rows[i].ctl, rows[i].rt, rows[i].wt);
            stall <= rows[i].st;
            acc(28'h0000020, rows[i].sz, rows[i].w, 32'hA5C35A3C);
            check(32'(n), 32'(rows[i].lat));
        end
        stall <= 4'h0;
        cfg(16'h0011, 32'h00000101, 32'h0);
        acc(28'h0000010, 2'h2, 1'b1, 32'h1234ABCD);
        check(32'(mem_u.mem[8]), 32'h0000ABCD);
        check(32'(mem_u.mem[9]), 32'h00001234);
        acc(28'h0000010, 2'h2, 1'b0, 32'h0);
        check(acc_rdata, 32'h1234ABCD);
        acc(28'h0000011, 2'h0, 1'b1, 32'h000000EE);
        check(32'(bl_seen), 32'h00000001);
        cfg(16'h0011, 32'h000F0101, 32'h0);
        acc(28'h0000020, 2'h1, 1'b0, 32'h0);
        acc(28'h0000020, 2'h1, 1'b0, 32'h0);
        check(32'(gap >= 15), 32'h1);
        acc(28'h4000020, 2'h1, 1'b0, 32'h0);
        check(32'(n), 32'h4);
        check(32'(acc_err), 32'h1);
        conclude();
    end
endmodule : testbench

bind asmt_ctrl asmt_ctrl_sva chk_u (.clock(clock), .rst(rst), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_ack(wb_ack), .acc_ack(acc_ack), .acc_err(acc_err), .pins(pins));

// File: verilog/asmt_cfg_mem.sv
`timescale 1ns/1ps
`include "asmt_consts.svh"

module asmt_cfg_mem (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Write port
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [3:0] wr_be,
    input wire logic [31:0] wr_data,
    // Read ports, data one cycle after index
    input wire logic [3:0][3:0] rd_idx,
    output logic [3:0][31:0] rd_data
);

    asmt_pkg::asmt_word_t mem_r [16];

    function automatic asmt_pkg::asmt_word_t rst_val(input logic [3:0] idx);
        asmt_pkg::asmt_word_t v;
        v = `ASMT_RST_LAT;
        case (idx[1:0])
            `ASMT_SLOT_CTL: v = (idx[3:2] == 2'h0) ? `ASMT_RST_CTL0 : `ASMT_RST_CTLN;
            `ASMT_SLOT_RTIM: v = `ASMT_RST_TIM;
            `ASMT_SLOT_WTIM: v = `ASMT_RST_TIM;
            default: v = `ASMT_RST_LAT;
        endcase
        return v;
    endfunction : rst_val

    genvar k;
    generate
        for (k = 0; k < 16; k++) begin : g_word
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    mem_r[k] <= rst_val(4'(k));
                end else if (wr_en && wr_idx == 4'(k)) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wr_be[b]) begin
                            mem_r[k][8*b +: 8] <= wr_data[8*b +: 8];
                        end
                    end
                end
            end
        end
        for (k = 0; k < 4; k++) begin : g_rd
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    rd_data[k] <= 32'h00000000;
                end else begin
                    rd_data[k] <= mem_r[rd_idx[k]];
                end
            end
        end
    endgenerate

endmodule : asmt_cfg_mem

// File: verilog/asmt_consts.svh
`ifndef ASMT_CONSTS_SVH
`define ASMT_CONSTS_SVH

// Region control word fields
`define ASMT_CTL_BANK_EN 0
`define ASMT_CTL_MUX 1
`define ASMT_CTL_TYPE 2
`define ASMT_CTL_WIDTH 4
`define ASMT_CTL_FLASH_EN 6
`define ASMT_CTL_WAIT_POL 9
`define ASMT_CTL_EXT 14
`define ASMT_CTL_WAIT_EN 15
`define ASMT_CTL_BYTE_LANE_SETUP_CYCLES 22

// Read and write timing word fields
`define ASMT_TIM_READ_ADDRESS_SETUP_CYCLES 0
`define ASMT_TIM_READ_ADDRESS_HOLD_CYCLES 4
`define ASMT_TIM_READ_DATA_SETUP_CYCLES 8
`define ASMT_TIM_TURN 16
`define ASMT_TIM_MODEL 28

// Field encodings
`define ASMT_TYPE_NOR 2'h2
`define ASMT_WIDTH_16 2'h1
`define ASMT_EXT_ON 1'h1
`define ASMT_MODEL_A 2'h0
`define ASMT_MODEL_B 2'h1
`define ASMT_MODEL_C 2'h2
`define ASMT_MODEL_D 2'h3
`define ASMT_SIZE_8 2'h0
`define ASMT_SIZE_16 2'h1
`define ASMT_SIZE_32 2'h2

// Data phase extra cycles
`define ASMT_WR_DATA_EXTRA 9'h001
`define ASMT_RD_DATA_EXTRA 9'h003

// Register map: region r, slot s at byte 0x10*r + 4*s
`define ASMT_SLOT_CTL 2'h0
`define ASMT_SLOT_RTIM 2'h1
`define ASMT_SLOT_WTIM 2'h2
`define ASMT_SLOT_LAT 2'h3
`define ASMT_OFF_STATUS 7'h40

// Reset values
`define ASMT_RST_CTL0 32'h000030DA
`define ASMT_RST_CTLN 32'h000030D2
`define ASMT_RST_TIM 32'h0FFFFFFF
`define ASMT_RST_LAT 32'h00000000

`endif

// File: verilog/asmt_ctrl.sv
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "asmt_consts.svh"

module asmt_ctrl (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Wishbone register slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [6:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_wdat,
    output logic [31:0] wb_rdat,
    output logic wb_ack,
    // Memory access request
    input wire logic acc_valid,
    input wire asmt_pkg::asmt_req_s acc_req,
    output logic acc_ack,
    output logic acc_err,
    output logic [31:0] acc_rdata,
    // External memory pins
    output asmt_pkg::asmt_pins_s pins,
    input wire logic wait_n,
    input wire logic [15:0] ext_data_in
);

    asmt_pkg::asmt_state_e state_r;
    logic [8:0] cnt_r;
    asmt_pkg::asmt_step_s step_nxt;
    asmt_pkg::asmt_req_s req_r;
    asmt_pkg::asmt_tim_s tim_r;
    logic read_address_hold_cycles_on_r, oe_tog_r, adv_c_r, adv_on_r, bl_use_r, mux_r;
    logic wait_en_r, wait_pol_r, wide_r, err_r;
    logic [1:0] byte_lane_setup_cycles_r;
    logic [2:0] beats_r, beat_r;
    logic [3:0] gap_cnt_r;
    logic [1:0] gap_reg_r;
    logic wb_pend_r;
    logic [3:0][3:0] rd_idx;
    logic [3:0][31:0] rd_data;
    logic [1:0] region;
    logic gap_block, wait_act, data_end, last_beat, in_acc, in_addr;
    logic [25:0] bus_addr;
    logic [25:0] ext_addr;
    logic [15:0] wr_lane;
    logic [1:0] lanes;
    logic [8:0] remain;
    logic [3:0] read_address_hold_cycles_eff;
    asmt_pkg::asmt_word_t ctl_w;
    asmt_pkg::asmt_tim_s rtim_w, wtim_w;
    logic ext_w, nor_w;
    logic [1:0] mdl_w;
    asmt_pkg::asmt_word_t status_w;

    function automatic asmt_pkg::asmt_tim_s tim_of(input asmt_pkg::asmt_word_t w);
        asmt_pkg::asmt_tim_s t;
        t.model = w[`ASMT_TIM_MODEL +: 2];
        t.turn = w[`ASMT_TIM_TURN +: 4];
        t.read_data_setup_cycles = w[`ASMT_TIM_READ_DATA_SETUP_CYCLES +: 8];
        t.read_address_hold_cycles = w[`ASMT_TIM_READ_ADDRESS_HOLD_CYCLES +: 4];
        t.read_address_setup_cycles = w[`ASMT_TIM_READ_ADDRESS_SETUP_CYCLES +: 4];
        return t;
    endfunction : tim_of

    function automatic asmt_pkg::asmt_step_s data_step(input logic we,
                                                        input asmt_pkg::asmt_tim_s t);
        asmt_pkg::asmt_step_s s;
        s.st = asmt_pkg::ST_DATA;
        s.cnt = {1'b0, t.read_data_setup_cycles} + (we ? `ASMT_WR_DATA_EXTRA : `ASMT_RD_DATA_EXTRA);
        return s;
    endfunction : data_step

    function automatic asmt_pkg::asmt_step_s addr_step(input logic we, input logic hold_on,
                                                        input asmt_pkg::asmt_tim_s t);
        asmt_pkg::asmt_step_s s;
        if (hold_on && t.read_address_hold_cycles != 4'h0) begin
            s.st = asmt_pkg::ST_READ_ADDRESS_HOLD_CYCLES;
            s.cnt = {5'h00, t.read_address_hold_cycles};
        end else begin
            s = data_step(we, t);
        end
        return s;
    endfunction : addr_step

    function automatic asmt_pkg::asmt_step_s first_step(input logic we, input logic hold_on,
                                                         input asmt_pkg::asmt_tim_s t);
        asmt_pkg::asmt_step_s s;
        if (t.read_address_setup_cycles != 4'h0) begin
            s.st = asmt_pkg::ST_READ_ADDRESS_SETUP_CYCLES;
            s.cnt = {5'h00, t.read_address_setup_cycles};
        end else begin
            s = addr_step(we, hold_on, t);
        end
        return s;
    endfunction : first_step

    // Configuration store
    assign region = (state_r == asmt_pkg::ST_IDLE) ? acc_req.addr[27:26] : req_r.addr[27:26];
    assign rd_idx[0] = wb_adr[5:2];
    assign rd_idx[1] = {region, `ASMT_SLOT_CTL};
    assign rd_idx[2] = {region, `ASMT_SLOT_RTIM};
    assign rd_idx[3] = {region, `ASMT_SLOT_WTIM};

    asmt_cfg_mem u_cfg (
        .clock(clock),
        .rst(rst),
        // Write lands only at the edge where the master sees ack
        .wr_en(wb_ack && wb_cyc && wb_stb && wb_we && !wb_adr[6]),
        .wr_idx(wb_adr[5:2]),
        .wr_be(wb_sel),
        .wr_data(wb_wdat),
        .rd_idx(rd_idx),
        .rd_data(rd_data)
    );

    // Wishbone slave: sample, then ack two edges after the request is seen
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wb_pend_r <= 1'b0;
            wb_ack <= 1'b0;
            wb_rdat <= 32'h00000000;
        end else begin
            wb_pend_r <= wb_cyc && wb_stb && !wb_ack && !wb_pend_r;
            wb_ack <= wb_pend_r;
            if (wb_pend_r) begin
                if (!wb_adr[6]) begin
                    wb_rdat <= rd_data[0];
                end else if (wb_adr[6:2] == 5'(`ASMT_OFF_STATUS >> 2)) begin
                    wb_rdat <= status_w;
                end else begin
                    wb_rdat <= 32'h00000000;
                end
            end
        end
    end

    assign status_w = {26'h0000000, req_r.addr[27:26], 1'b0, acc_err, gap_cnt_r != 4'h0,
                       state_r != asmt_pkg::ST_IDLE};

    // Decode of the fetched region words
    assign ctl_w = rd_data[1];
    assign rtim_w = tim_of(rd_data[2]);
    assign wtim_w = tim_of(rd_data[3]);
    assign ext_w = ctl_w[`ASMT_CTL_EXT] == `ASMT_EXT_ON;
    assign nor_w = ctl_w[`ASMT_CTL_TYPE +: 2] == `ASMT_TYPE_NOR && ctl_w[`ASMT_CTL_FLASH_EN];
    assign mdl_w = req_r.we ? wtim_w.model : rtim_w.model;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tim_r <= '0;
            read_address_hold_cycles_on_r <= 1'b0;
            oe_tog_r <= 1'b0;
            adv_c_r <= 1'b0;
            adv_on_r <= 1'b0;
            bl_use_r <= 1'b0;
            mux_r <= 1'b0;
            wait_en_r <= 1'b0;
            wait_pol_r <= 1'b0;
            wide_r <= 1'b0;
            byte_lane_setup_cycles_r <= 2'h0;
            beats_r <= 3'h1;
            err_r <= 1'b0;
        end else if (state_r == asmt_pkg::ST_LOAD) begin
            // Timing is frozen per access so register writes cannot tear it
            tim_r <= (ext_w && req_r.we) ? wtim_w : rtim_w;
            mux_r <= ctl_w[`ASMT_CTL_MUX] && nor_w;
            read_address_hold_cycles_on_r <= (ctl_w[`ASMT_CTL_MUX] && nor_w)
                         || (ext_w && mdl_w == `ASMT_MODEL_D);
            oe_tog_r <= ext_w && (mdl_w == `ASMT_MODEL_C
                         || (mdl_w == `ASMT_MODEL_A && !nor_w));
            adv_c_r <= ext_w && mdl_w == `ASMT_MODEL_C;
            adv_on_r <= nor_w;
            bl_use_r <= !nor_w || (ext_w && mdl_w == `ASMT_MODEL_D);
            wait_en_r <= ctl_w[`ASMT_CTL_WAIT_EN];
            wait_pol_r <= ctl_w[`ASMT_CTL_WAIT_POL];
            wide_r <= ctl_w[`ASMT_CTL_WIDTH +: 2] == `ASMT_WIDTH_16;
            byte_lane_setup_cycles_r <= ctl_w[`ASMT_CTL_BYTE_LANE_SETUP_CYCLES +: 2];
            err_r <= !ctl_w[`ASMT_CTL_BANK_EN];
            case (req_r.size)
                `ASMT_SIZE_8: beats_r <= 3'h1;
                `ASMT_SIZE_16: beats_r <= (ctl_w[`ASMT_CTL_WIDTH +: 2] == `ASMT_WIDTH_16)
                                          ? 3'h1 : 3'h2;
                default: beats_r <= (ctl_w[`ASMT_CTL_WIDTH +: 2] == `ASMT_WIDTH_16)
                                    ? 3'h2 : 3'h4;
            endcase
        end
    end

    // Wait is honoured only when enabled; polarity 1 means active high
    assign wait_act = wait_en_r && (wait_pol_r ? wait_n : !wait_n);
    assign data_end = state_r == asmt_pkg::ST_DATA && cnt_r == 9'h001 && !wait_act;
    assign last_beat = beat_r == beats_r - 3'h1;
    assign gap_block = gap_cnt_r != 4'h0 && acc_req.addr[27:26] == gap_reg_r;

    // Phase sequencing
    always_comb begin
        step_nxt.st = state_r;
        step_nxt.cnt = cnt_r;
        case (state_r)
            asmt_pkg::ST_IDLE: begin
                if (acc_valid && !acc_ack && !gap_block) begin
                    step_nxt.st = asmt_pkg::ST_LOAD;
                end
            end
            asmt_pkg::ST_LOAD: begin
                step_nxt.st = asmt_pkg::ST_START;
            end
            asmt_pkg::ST_START: begin
                if (err_r) begin
                    step_nxt.st = asmt_pkg::ST_DONE;
                end else begin
                    step_nxt = first_step(req_r.we, read_address_hold_cycles_on_r, tim_r);
                end
            end
            asmt_pkg::ST_READ_ADDRESS_SETUP_CYCLES: begin
                if (cnt_r == 9'h001) begin
                    step_nxt = addr_step(req_r.we, read_address_hold_cycles_on_r, tim_r);
                end else begin
                    step_nxt.cnt = cnt_r - 9'h001;
                end
            end
            asmt_pkg::ST_READ_ADDRESS_HOLD_CYCLES: begin
                if (cnt_r == 9'h001) begin
                    step_nxt = data_step(req_r.we, tim_r);
                end else begin
                    step_nxt.cnt = cnt_r - 9'h001;
                end
            end
            asmt_pkg::ST_DATA: begin
                if (wait_act) begin
                    step_nxt.cnt = cnt_r;
                end else if (cnt_r != 9'h001) begin
                    step_nxt.cnt = cnt_r - 9'h001;
                end else if (last_beat) begin
                    step_nxt.st = asmt_pkg::ST_DONE;
                end else begin
                    step_nxt = first_step(req_r.we, read_address_hold_cycles_on_r, tim_r);
                end
            end
            asmt_pkg::ST_DONE: begin
                step_nxt.st = asmt_pkg::ST_IDLE;
            end
            default: begin
                step_nxt.st = asmt_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= asmt_pkg::ST_IDLE;
            cnt_r <= 9'h000;
        end else begin
            state_r <= step_nxt.st;
            cnt_r <= step_nxt.cnt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            req_r <= '0;
        end else if (state_r == asmt_pkg::ST_IDLE && step_nxt.st == asmt_pkg::ST_LOAD) begin
            req_r <= acc_req;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            beat_r <= 3'h0;
        end else if (state_r == asmt_pkg::ST_START) begin
            beat_r <= 3'h0;
        end else if (data_end && !last_beat) begin
            beat_r <= beat_r + 3'h1;
        end
    end

    // Turnaround guard, counted from the end of the access
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gap_cnt_r <= 4'h0;
            gap_reg_r <= 2'h0;
        end else if (state_r == asmt_pkg::ST_DONE) begin
            gap_cnt_r <= err_r ? 4'h0 : tim_r.turn;
            gap_reg_r <= req_r.addr[27:26];
        end else if (gap_cnt_r != 4'h0) begin
            gap_cnt_r <= gap_cnt_r - 4'h1;
        end
    end

    // Requester answer; read beats packed from bit 0 upward
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acc_ack <= 1'b0;
            acc_err <= 1'b0;
            acc_rdata <= 32'h00000000;
        end else begin
            acc_ack <= state_r == asmt_pkg::ST_DONE;
            if (state_r == asmt_pkg::ST_DONE) begin
                acc_err <= err_r;
            end
            if (state_r == asmt_pkg::ST_START) begin
                acc_rdata <= 32'h00000000;
            end else if (data_end && !req_r.we) begin
                if (wide_r) begin
                    acc_rdata[16*beat_r[0] +: 16] <= ext_data_in;
                end else begin
                    acc_rdata[8*beat_r[1:0] +: 8] <= ext_data_in[7:0];
                end
            end
        end
    end

    // Beat address and data
    assign bus_addr = req_r.addr[25:0] + (wide_r ? {22'h000000, beat_r, 1'b0}
                                                 : {23'h000000, beat_r});
    assign ext_addr = wide_r ? {1'b0, bus_addr[25:1]} : bus_addr;
    assign wr_lane = wide_r ? ((req_r.size == `ASMT_SIZE_8) ? {2{req_r.wdata[7:0]}}
                                                           : req_r.wdata[16*beat_r[0] +: 16])
                            : {8'h00, req_r.wdata[8*beat_r[1:0] +: 8]};
    assign lanes = (req_r.we && wide_r && req_r.size == `ASMT_SIZE_8)
                   ? (bus_addr[0] ? 2'b01 : 2'b10) : 2'b00;
    assign in_addr = state_r == asmt_pkg::ST_READ_ADDRESS_SETUP_CYCLES || state_r == asmt_pkg::ST_READ_ADDRESS_HOLD_CYCLES;
    assign in_acc = in_addr || state_r == asmt_pkg::ST_DATA;
    assign read_address_hold_cycles_eff = (read_address_hold_cycles_on_r && tim_r.read_address_hold_cycles != 4'h0) ? tim_r.read_address_hold_cycles : 4'h0;
    assign remain = (state_r == asmt_pkg::ST_READ_ADDRESS_SETUP_CYCLES) ? cnt_r + {5'h00, read_address_hold_cycles_eff} : cnt_r;

    // Pins are registered decodes of the phase, so each moves on a rising edge only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pins <= '{cs_n: 4'hF, oe_n: 1'b1, we_n: 1'b1, adv_n: 1'b1, bl_n: 2'b11,
                      addr: 26'h0000000, dout: 16'h0000, doe: 1'b0};
        end else begin
            pins.cs_n <= in_acc ? ~(4'h1 << req_r.addr[27:26]) : 4'hF;
            pins.adv_n <= !(adv_on_r && state_r == asmt_pkg::ST_READ_ADDRESS_SETUP_CYCLES
                            && (!adv_c_r || cnt_r == {5'h00, tim_r.read_address_setup_cycles}));
            pins.oe_n <= !(!req_r.we && (state_r == asmt_pkg::ST_DATA
                           || (in_addr && !oe_tog_r && !mux_r)));
            pins.we_n <= !(req_r.we && state_r == asmt_pkg::ST_DATA && cnt_r != 9'h001);
            if (!in_acc) begin
                pins.bl_n <= 2'b11;
            end else if (!bl_use_r || state_r == asmt_pkg::ST_DATA
                         || remain <= {7'h00, byte_lane_setup_cycles_r}) begin
                pins.bl_n <= lanes;
            end else begin
                pins.bl_n <= 2'b11;
            end
            if (in_acc) begin
                pins.addr <= ext_addr;
            end
            if (mux_r && in_addr) begin
                pins.dout <= ext_addr[15:0];
                pins.doe <= 1'b1;
            end else if (req_r.we && state_r == asmt_pkg::ST_DATA) begin
                pins.dout <= wr_lane;
                pins.doe <= 1'b1;
            end else begin
                pins.doe <= 1'b0;
            end
        end
    end

endmodule : asmt_ctrl

// File: verilog/asmt_pkg.sv
package asmt_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD,
        ST_START,
        ST_READ_ADDRESS_SETUP_CYCLES,
        ST_READ_ADDRESS_HOLD_CYCLES,
        ST_DATA,
        ST_DONE
    } asmt_state_e;

    typedef logic [31:0] asmt_word_t;

    typedef struct packed {
        logic [27:0] addr;
        logic [1:0] size;
        logic we;
        logic [31:0] wdata;
    } asmt_req_s;

    typedef struct packed {
        logic [1:0] model;
        logic [3:0] turn;
        logic [7:0] read_data_setup_cycles;
        logic [3:0] read_address_hold_cycles;
        logic [3:0] read_address_setup_cycles;
    } asmt_tim_s;

    typedef struct packed {
        asmt_state_e st;
        logic [8:0] cnt;
    } asmt_step_s;

    typedef struct packed {
        logic [3:0] cs_n;
        logic oe_n;
        logic we_n;
        logic adv_n;
        logic [1:0] bl_n;
        logic [25:0] addr;
        logic [15:0] dout;
        logic doe;
    } asmt_pins_s;

endpackage : asmt_pkg
